// file: shared/csp_pkg.sv
package csp_pkg;

    // ***************************************************************
    // register space offsets
    // ***************************************************************
    localparam logic [7:0] CSP_ADDR_STACK_TOP    = 8'h81;
    localparam logic [7:0] CSP_ADDR_DATA_POINTER_16_LOW     = 8'h82;
    localparam logic [7:0] CSP_ADDR_DATA_POINTER_16_HIGH    = 8'h83;
    localparam logic [7:0] CSP_ADDR_STATUS_WORD  = 8'hD0;
    localparam logic [7:0] CSP_ADDR_ACCUMULATOR  = 8'hE0;

    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic [7:0]  CSP_RST_STACK_TOP    = 8'h07;
    localparam logic [7:0]  CSP_RST_STATUS_WORD  = 8'h00;
    localparam logic [15:0] CSP_RST_DATA_POINTER_16         = 16'h0000;
    localparam logic [7:0]  CSP_RST_ACCUMULATOR  = 8'h00;
    localparam logic [7:0]  CSP_RST_RD_DATA      = 8'h00;

    // ***************************************************************
    // status word field positions
    // ***************************************************************
    localparam int CSP_BIT_CARRY   = 7;
    localparam int CSP_BIT_AUX     = 6;
    localparam int CSP_BIT_USER_A  = 5;
    localparam int CSP_BIT_BANK_HI = 4;
    localparam int CSP_BIT_BANK_LO = 3;
    localparam int CSP_BIT_OVF     = 2;
    localparam int CSP_BIT_USER_B  = 1;
    localparam int CSP_BIT_PARITY  = 0;

    // bits that software may write; parity is read-only
    localparam logic [7:0] CSP_STATUS_WR_MASK = 8'hFE;

    // ***************************************************************
    // carriers
    // ***************************************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       wr;
        logic       rd;
    } csp_sfr_req_t;

    typedef struct packed {
        logic valid;
        logic carry;
        logic aux;
        logic ovf;
    } csp_alu_flags_t;

    function automatic logic csp_odd_parity(input logic [7:0] value);
        return ^value;
    endfunction

endpackage

// file: rtl/csp_stack_ram.sv
`timescale 1ns/10ps
module csp_stack_ram import csp_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wrData,
    output logic      [DATA_W-1:0] rdData
);

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] rdData_ff;

    // contents carry no reset; the read register has no reset either
    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
        rdData_ff <= mem[addr];
    end

    assign rdData = rdData_ff;

endmodule // csp_stack_ram

// file: rtl/csp_core_regs.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module csp_core_regs import csp_pkg::*; #(
    parameter int STACK_ADDR_W = 8
) (
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  wire csp_sfr_req_t   sfrReq,
    output logic        [7:0]   sfrRdData,
    input  wire csp_alu_flags_t aluFlags,
    input  wire logic           accumWrEn,
    input  wire logic   [7:0]   accumWrData,
    input  wire logic           dptrLoad,
    input  wire logic   [15:0]  dptrLoadData,
    input  wire logic           pushReq,
    input  wire logic   [7:0]   pushData,
    input  wire logic           popReq,
    output logic                popValid,
    output logic        [7:0]   popData,
    output logic        [7:0]   stackTopPointer,
    output logic        [15:0]  dataPointer16,
    output logic        [7:0]   programStatusWord,
    output logic        [7:0]   accumulatorReg,
    output logic        [4:0]   bankBaseAddr
);

    // ***************************************************************
    // state
    // ***************************************************************
    typedef struct packed {
        logic [7:0]  stackTop;
        logic [15:0] data_pointer_16;
        logic [7:0]  status;
        logic [7:0]  accum;
        logic [4:0]  bankBase;
        logic [7:0]  rdData;
        logic        popValid;
    } csp_state_t;

    csp_state_t state_ff;
    csp_state_t nxt_state;

    logic                    sfrWrStack;
    logic                    sfrWrStatus;
    logic                    doPush;
    logic                    doPop;
    logic                    ramWrEn;
    logic [STACK_ADDR_W-1:0] ramAddr;
    logic [7:0]              stackInc;
    logic [7:0]              ramRdData;

    assign sfrWrStack  = sfrReq.wr && (sfrReq.addr == CSP_ADDR_STACK_TOP);
    assign sfrWrStatus = sfrReq.wr && (sfrReq.addr == CSP_ADDR_STATUS_WORD);
    // push beats pop when both arrive; the lost pop is the datapath's fault
    assign doPush      = pushReq;
    assign doPop       = popReq && !pushReq;
    assign stackInc    = state_ff.stackTop + 8'h01;

    // ***************************************************************
    // stack memory
    // ***************************************************************
    always_comb begin
        ramWrEn = doPush;
        if (doPush) begin
            ramAddr = stackInc[STACK_ADDR_W-1:0];
        end else begin
            ramAddr = state_ff.stackTop[STACK_ADDR_W-1:0];
        end
    end

    csp_stack_ram #(
        .ADDR_W (STACK_ADDR_W),
        .DATA_W (8)
    ) u_stack_ram (
        .clk_sys (clk_sys),
        .wrEn    (ramWrEn),
        .addr    (ramAddr),
        .wrData  (pushData),
        .rdData  (ramRdData)
    );

    // ***************************************************************
    // next state
    // ***************************************************************
    always_comb begin
        nxt_state = state_ff;

        // stack pointer: a software write wins over push and pop
        if (sfrWrStack) begin
            nxt_state.stackTop = sfrReq.wrData;
        end else if (doPush) begin
            nxt_state.stackTop = stackInc;
        end else if (doPop) begin
            nxt_state.stackTop = state_ff.stackTop - 8'h01;
        end
        nxt_state.popValid = doPop;

        // data pointer halves
        if (dptrLoad) begin
            nxt_state.data_pointer_16 = dptrLoadData;
        end
        if (sfrReq.wr && (sfrReq.addr == CSP_ADDR_DATA_POINTER_16_LOW)) begin
            nxt_state.data_pointer_16[7:0] = sfrReq.wrData;
        end
        if (sfrReq.wr && (sfrReq.addr == CSP_ADDR_DATA_POINTER_16_HIGH)) begin
            nxt_state.data_pointer_16[15:8] = sfrReq.wrData;
        end

        // accumulator
        if (sfrReq.wr && (sfrReq.addr == CSP_ADDR_ACCUMULATOR)) begin
            nxt_state.accum = sfrReq.wrData;
        end else if (accumWrEn) begin
            nxt_state.accum = accumWrData;
        end

        // status word; software write beats an arithmetic update
        if (sfrWrStatus) begin
            nxt_state.status = (sfrReq.wrData & CSP_STATUS_WR_MASK);
        end else if (aluFlags.valid) begin
            nxt_state.status[CSP_BIT_CARRY] = aluFlags.carry;
            nxt_state.status[CSP_BIT_AUX]   = aluFlags.aux;
            nxt_state.status[CSP_BIT_OVF]   = aluFlags.ovf;
        end
        // parity tracks the accumulator that will stand next cycle
        nxt_state.status[CSP_BIT_PARITY] = csp_odd_parity(nxt_state.accum);
        nxt_state.bankBase = {nxt_state.status[CSP_BIT_BANK_HI:CSP_BIT_BANK_LO],
                              3'h0};

        // read data stand only in the cycle after the read strobe
        nxt_state.rdData = CSP_RST_RD_DATA;
        if (sfrReq.rd) begin
            unique case (sfrReq.addr)
                CSP_ADDR_STACK_TOP:   nxt_state.rdData = state_ff.stackTop;
                CSP_ADDR_DATA_POINTER_16_LOW:    nxt_state.rdData = state_ff.data_pointer_16[7:0];
                CSP_ADDR_DATA_POINTER_16_HIGH:   nxt_state.rdData = state_ff.data_pointer_16[15:8];
                CSP_ADDR_STATUS_WORD: nxt_state.rdData = state_ff.status;
                CSP_ADDR_ACCUMULATOR: nxt_state.rdData = state_ff.accum;
                default:              nxt_state.rdData = CSP_RST_RD_DATA;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff.stackTop <= CSP_RST_STACK_TOP;
            state_ff.data_pointer_16     <= CSP_RST_DATA_POINTER_16;
            state_ff.status   <= CSP_RST_STATUS_WORD;
            state_ff.accum    <= CSP_RST_ACCUMULATOR;
            state_ff.bankBase <= {CSP_RST_STATUS_WORD[CSP_BIT_BANK_HI:CSP_BIT_BANK_LO], 3'h0};
            state_ff.rdData   <= CSP_RST_RD_DATA;
            state_ff.popValid <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    assign sfrRdData         = state_ff.rdData;
    assign popValid          = state_ff.popValid;
    assign popData           = ramRdData;
    assign stackTopPointer   = state_ff.stackTop;
    assign dataPointer16     = state_ff.data_pointer_16;
    assign programStatusWord = state_ff.status;
    assign accumulatorReg    = state_ff.accum;
    assign bankBaseAddr      = state_ff.bankBase;

    // ***************************************************************
    // assertions
    // ***************************************************************
    property p_pushInc;
        @(posedge clk_sys) disable iff (rst)
        pushReq && !sfrWrStack |=> stackTopPointer == $past(stackTopPointer) + 8'h01;
    endproperty
    a_pushInc: assert property (p_pushInc) else $error("push did not increment");

    property p_resetStack;
        @(posedge clk_sys) rst |=> stackTopPointer == CSP_RST_STACK_TOP;
    endproperty
    a_resetStack: assert property (p_resetStack) else $error("bad stack reset");

    property p_dptrHigh;
        @(posedge clk_sys) disable iff (rst)
        sfrReq.wr && sfrReq.addr == CSP_ADDR_DATA_POINTER_16_HIGH
            |=> dataPointer16[15:8] == $past(sfrReq.wrData);
    endproperty
    a_dptrHigh: assert property (p_dptrHigh) else $error("high byte lost");

    property p_dptrLoad;
        @(posedge clk_sys) disable iff (rst)
        dptrLoad && !sfrReq.wr |=> dataPointer16 == $past(dptrLoadData);
    endproperty
    a_dptrLoad: assert property (p_dptrLoad) else $error("pointer load lost");

    property p_carry;
        @(posedge clk_sys) disable iff (rst)
        aluFlags.valid && !sfrWrStatus
            |=> programStatusWord[CSP_BIT_CARRY] == $past(aluFlags.carry);
    endproperty
    a_carry: assert property (p_carry) else $error("carry mismatch");

    property p_aux;
        @(posedge clk_sys) disable iff (rst)
        aluFlags.valid && !sfrWrStatus
            |=> programStatusWord[CSP_BIT_AUX] == $past(aluFlags.aux);
    endproperty
    a_aux: assert property (p_aux) else $error("aux carry mismatch");

    property p_ovf;
        @(posedge clk_sys) disable iff (rst)
        aluFlags.valid && !sfrWrStatus
            |=> programStatusWord[CSP_BIT_OVF] == $past(aluFlags.ovf);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow mismatch");

    property p_bank;
        @(posedge clk_sys) disable iff (rst)
        sfrWrStatus |=> bankBaseAddr == {$past(sfrReq.wrData[4:3]), 3'h0};
    endproperty
    a_bank: assert property (p_bank) else $error("bank base wrong");

    property p_parity;
        @(posedge clk_sys) disable iff (rst)
        programStatusWord[CSP_BIT_PARITY] == ^accumulatorReg;
    endproperty
    a_parity: assert property (p_parity) else $error("parity wrong");

    property p_userFlags;
        @(posedge clk_sys) disable iff (rst)
        !sfrWrStatus |=> $stable(programStatusWord[CSP_BIT_USER_A])
            && $stable(programStatusWord[CSP_BIT_USER_B]);
    endproperty
    a_userFlags: assert property (p_userFlags) else $error("user flag moved");

    property p_accumReset;
        @(posedge clk_sys) rst |=> accumulatorReg == CSP_RST_ACCUMULATOR;
    endproperty
    a_accumReset: assert property (p_accumReset) else $error("bad accumulator reset");

    property p_pop;
        @(posedge clk_sys) disable iff (rst)
        popReq && !pushReq && !sfrWrStack
            |=> popValid && stackTopPointer == $past(stackTopPointer) - 8'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("pop misbehaved");

    property p_statusReset;
        @(posedge clk_sys) rst |=> programStatusWord == CSP_RST_STATUS_WORD;
    endproperty
    a_statusReset: assert property (p_statusReset) else $error("bad status reset");

    property p_dptrLow;
        @(posedge clk_sys) disable iff (rst)
        sfrReq.wr && sfrReq.addr == CSP_ADDR_DATA_POINTER_16_LOW
            |=> dataPointer16[7:0] == $past(sfrReq.wrData);
    endproperty
    a_dptrLow: assert property (p_dptrLow) else $error("low byte lost");

    property p_rdDptrLow;
        @(posedge clk_sys) disable iff (rst)
        sfrReq.rd && sfrReq.addr == CSP_ADDR_DATA_POINTER_16_LOW
            |=> sfrRdData == $past(dataPointer16[7:0]);
    endproperty
    a_rdDptrLow: assert property (p_rdDptrLow) else $error("low byte read wrong");

    property p_rdDptrHigh;
        @(posedge clk_sys) disable iff (rst)
        sfrReq.rd && sfrReq.addr == CSP_ADDR_DATA_POINTER_16_HIGH
            |=> sfrRdData == $past(dataPointer16[15:8]);
    endproperty
    a_rdDptrHigh: assert property (p_rdDptrHigh) else $error("high byte read wrong");

    property p_statusWrite;
        @(posedge clk_sys) disable iff (rst)
        sfrWrStatus
            |=> programStatusWord[7:1] == $past(sfrReq.wrData[7:1]);
    endproperty
    a_statusWrite: assert property (p_statusWrite) else $error("status write lost");

    property p_rdStatus;
        @(posedge clk_sys) disable iff (rst)
        sfrReq.rd && sfrReq.addr == CSP_ADDR_STATUS_WORD
            |=> sfrRdData == $past(programStatusWord);
    endproperty
    a_rdStatus: assert property (p_rdStatus) else $error("status read wrong");

    // the byte pushed just before a pop must come back from the read register
    property p_pushPop;
        @(posedge clk_sys) disable iff (rst)
        pushReq && !sfrWrStack ##1 popReq && !pushReq && !sfrWrStack
            |=> popData == $past(pushData, 2);
    endproperty
    a_pushPop: assert property (p_pushPop) else $error("pop lost pushed byte");

    property p_noPopOnPush;
        @(posedge clk_sys) disable iff (rst)
        pushReq |=> !popValid;
    endproperty
    a_noPopOnPush: assert property (p_noPopOnPush) else $error("pop beside push");

    property p_accumWrite;
        @(posedge clk_sys) disable iff (rst)
        sfrReq.wr && sfrReq.addr == CSP_ADDR_ACCUMULATOR
            |=> accumulatorReg == $past(sfrReq.wrData);
    endproperty
    a_accumWrite: assert property (p_accumWrite) else $error("accumulator write lost");

    // flags stand until the next arithmetic result or software write
    property p_flagsHold;
        @(posedge clk_sys) disable iff (rst)
        !aluFlags.valid && !sfrWrStatus |=> $stable(programStatusWord[CSP_BIT_CARRY])
            && $stable(programStatusWord[CSP_BIT_AUX]) && $stable(programStatusWord[CSP_BIT_OVF]);
    endproperty
    a_flagsHold: assert property (p_flagsHold) else $error("flag moved idle");

    property p_bankHold;
        @(posedge clk_sys) disable iff (rst)
        !sfrWrStatus |=> $stable(bankBaseAddr);
    endproperty
    a_bankHold: assert property (p_bankHold) else $error("bank moved idle");

    property p_stackHold;
        @(posedge clk_sys) disable iff (rst)
        !pushReq && !popReq && !sfrWrStack |=> $stable(stackTopPointer);
    endproperty
    a_stackHold: assert property (p_stackHold) else $error("stack pointer moved idle");

    c_pushPop: cover property (@(posedge clk_sys) disable iff (rst)
        pushReq ##1 popReq ##1 popValid);
    c_aluCarry: cover property (@(posedge clk_sys) disable iff (rst)
        aluFlags.valid && aluFlags.carry);
    c_bank3: cover property (@(posedge clk_sys) disable iff (rst) bankBaseAddr == 5'h18);
    c_readBack: cover property (@(posedge clk_sys) disable iff (rst)
        sfrReq.rd && sfrReq.addr == CSP_ADDR_STATUS_WORD);

endmodule // csp_core_regs

// file: tb/core_status_pointer_regs_tb_top.sv
`timescale 1ns/10ps
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin fails++; $display("[FAIL] t=%0t mismatch got %h exp %h", $time, (act), (exp)); end end

module core_status_pointer_regs_tb_top import csp_pkg::*; ;

    logic           clk_sys;
    logic           rst;
    csp_sfr_req_t   sfrReq;
    logic [7:0]     sfrRdData;
    csp_alu_flags_t aluFlags;
    logic           accumWrEn;
    logic [7:0]     accumWrData;
    logic           dptrLoad;
    logic [15:0]    dptrLoadData;
    logic           pushReq;
    logic [7:0]     pushData;
    logic           popReq;
    logic           popValid;
    logic [7:0]     popData;
    logic [7:0]     stackTopPointer;
    logic [15:0]    dataPointer16;
    logic [7:0]     programStatusWord;
    logic [7:0]     accumulatorReg;
    logic [4:0]     bankBaseAddr;
    int             fails;
    int             check_count;

    csp_core_regs uut (
        .clk_sys           (clk_sys),
        .rst               (rst),
        .sfrReq            (sfrReq),
        .sfrRdData         (sfrRdData),
        .aluFlags          (aluFlags),
        .accumWrEn         (accumWrEn),
        .accumWrData       (accumWrData),
        .dptrLoad          (dptrLoad),
        .dptrLoadData      (dptrLoadData),
        .pushReq           (pushReq),
        .pushData          (pushData),
        .popReq            (popReq),
        .popValid          (popValid),
        .popData           (popData),
        .stackTopPointer   (stackTopPointer),
        .dataPointer16     (dataPointer16),
        .programStatusWord (programStatusWord),
        .accumulatorReg    (accumulatorReg),
        .bankBaseAddr      (bankBaseAddr)
    );

    // ***************************************************************
    // clock and watchdog
    // ***************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // whole sequence needs well under 300 cycles; generous margin
    initial begin
        #100000;
        fails++;
        complete_run();
    end

    // ***************************************************************
    // access tasks
    // ***************************************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ends #1 after the taking edge so callers see settled outputs
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfrReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        sfrReq.wr <= 1'b0;
        #1;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        sfrReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        sfrReq.rd <= 1'b0;
        #1;
        `CHK(sfrRdData, e)
    endtask

    task automatic alu(input logic c, input logic ac, input logic o);
        @(posedge clk_sys);
        aluFlags <= '{valid: 1'b1, carry: c, aux: ac, ovf: o};
        @(posedge clk_sys);
        aluFlags.valid <= 1'b0;
        #1;
    endtask

    task automatic push(input logic [7:0] d);
        @(posedge clk_sys);
        pushReq  <= 1'b1;
        pushData <= d;
        @(posedge clk_sys);
        pushReq <= 1'b0;
        #1;
    endtask

    task automatic pop_chk(input logic [7:0] e);
        @(posedge clk_sys);
        popReq <= 1'b1;
        @(posedge clk_sys);
        popReq <= 1'b0;
        #1;
        `CHK(popValid, 1'b1)
        `CHK(popData, e)
    endtask

    // ***************************************************************
    // test sequence
    // ***************************************************************
    initial begin
        rst          = 1'b1;
        sfrReq       = '0;
        aluFlags     = '0;
        accumWrEn    = 1'b0;
        accumWrData  = 8'h00;
        dptrLoad     = 1'b0;
        dptrLoadData = 16'h0000;
        pushReq      = 1'b0;
        pushData     = 8'h00;
        popReq       = 1'b0;
        fails        = 0;
        check_count  = 0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        `CHK(stackTopPointer, 8'h07)
        `CHK(programStatusWord, 8'h00)
        chk_rd(CSP_ADDR_STACK_TOP, 8'h07);
        chk_rd(CSP_ADDR_STATUS_WORD, 8'h00);
        chk_rd(CSP_ADDR_ACCUMULATOR, 8'h00);
        chk_rd(8'h97, 8'h00);
        for (int b = 0; b < 4; b++) begin
            sfr_wr(CSP_ADDR_STATUS_WORD, 8'(b << 3));
            `CHK(bankBaseAddr, 5'(b * 8))
            chk_rd(CSP_ADDR_STATUS_WORD, 8'(b << 3));
        end
        // parity bit ignores the write and follows the accumulator
        sfr_wr(CSP_ADDR_STATUS_WORD, 8'hFF);
        `CHK(programStatusWord, 8'hFE)
        sfr_wr(CSP_ADDR_ACCUMULATOR, 8'h07);
        `CHK(programStatusWord, 8'hFF)
        @(posedge clk_sys);
        accumWrEn   <= 1'b1;
        accumWrData <= 8'h03;
        @(posedge clk_sys);
        accumWrEn <= 1'b0;
        #1;
        `CHK(programStatusWord, 8'hFE)
        // user flags set, then arithmetic flags toggled around them
        sfr_wr(CSP_ADDR_STATUS_WORD, 8'h22);
        alu(1'b1, 1'b0, 1'b1);
        `CHK(programStatusWord, 8'hA6)
        alu(1'b0, 1'b1, 1'b0);
        `CHK(programStatusWord, 8'h62)
        alu(1'b0, 1'b0, 1'b0);
        `CHK(programStatusWord, 8'h22)
        sfr_wr(CSP_ADDR_DATA_POINTER_16_LOW, 8'h34);
        sfr_wr(CSP_ADDR_DATA_POINTER_16_HIGH, 8'h12);
        `CHK(dataPointer16, 16'h1234)
        @(posedge clk_sys);
        dptrLoad     <= 1'b1;
        dptrLoadData <= 16'hABCD;
        @(posedge clk_sys);
        dptrLoad <= 1'b0;
        chk_rd(CSP_ADDR_DATA_POINTER_16_LOW, 8'hCD);
        chk_rd(CSP_ADDR_DATA_POINTER_16_HIGH, 8'hAB);
        sfr_wr(CSP_ADDR_DATA_POINTER_16_HIGH, 8'h00);
        `CHK(dataPointer16, 16'h00CD)
        push(8'hAA);
        `CHK(stackTopPointer, 8'h08)
        push(8'hBB);
        pop_chk(8'hBB);
        `CHK(stackTopPointer, 8'h08)
        pop_chk(8'hAA);
        `CHK(stackTopPointer, 8'h07)
        // pointer wraps modulo 256, pushes and pops back to back
        sfr_wr(CSP_ADDR_STACK_TOP, 8'hFF);
        push(8'h5A);
        `CHK(stackTopPointer, 8'h00)
        @(posedge clk_sys);
        pushReq  <= 1'b1;
        pushData <= 8'h11;
        @(posedge clk_sys);
        pushData <= 8'h22;
        @(posedge clk_sys);
        pushReq <= 1'b0;
        popReq  <= 1'b1;
        #1;
        `CHK(stackTopPointer, 8'h02)
        @(posedge clk_sys);
        #1;
        `CHK(popData, 8'h22)
        `CHK(popValid, 1'b1)
        @(posedge clk_sys);
        popReq <= 1'b0;
        #1;
        `CHK(popData, 8'h11)
        `CHK(stackTopPointer, 8'h00)
        pop_chk(8'h5A);
        `CHK(stackTopPointer, 8'hFF)
        // ***************************************************************
        // second reset in mid-run
        // ***************************************************************
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        `CHK(stackTopPointer, 8'h07)
        `CHK(programStatusWord, 8'h00)
        `CHK(accumulatorReg, 8'h00)
        complete_run();
    end

endmodule // core_status_pointer_regs_tb_top
